// [src/noise_random_source_regs.sv]
// AHB-lite register block of the random number generator.
// Assumes word-only accesses from the host and a synchronous noise input.
// Operation
// - Each value read returns a 16-bit number derived from analog noise.
// - Fresh values come no faster than one per 1.25 us.
// - Config bit 2 set stops the generator and its clock.
// - Ready flag at status bit 0; value read stalls while it is low.
// - Ready flag is one only while a fresh valid value is held.
// - Ready flag stays zero while the generator is disabled.
// - Value in bits 15:0; bits 31:16 read zero.
// - Config 0x00 RW, status 0x04 RO, value 0x08 RO, all reset zero.
`default_nettype none
module noise_random_source_regs #(
   parameter int SPACING = noise_pkg::SPACING_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic noise_in,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic generator_off
);
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      WRITE = 2'b01,
      WAIT_VALUE = 2'b10
   } phase_type;

   phase_type phase_r, phase_nxt;
   noise_pkg::bus_req_type req_r, req_nxt;
   logic [31:0] config_reg_r, config_reg_nxt;
   logic ready_r, ready_nxt;
   logic [15:0] sample_output_reg_r, sample_output_reg_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic fresh;
   logic [15:0] sample;
   logic take;
   logic value_read_done;
   logic fresh_ev;

   // The sampler keeps stepping while its fresh flag is high, so it only freezes
   // with the flag low while a value waits for the host. The raw flag is still
   // gated with ready_r, which keeps one word from landing twice.
   assign fresh_ev = fresh && !ready_r && !generator_off;

   assign generator_off = config_reg_r[noise_pkg::GENERATOR_OFF_BIT];
   assign take = hsel && hready && htrans[1];

   noise_sampler #(
      .SPACING(SPACING),
      .WIDTH(noise_pkg::SAMPLE_WIDTH)
   ) sampler (
      .mclk(mclk),
      .resetn(resetn),
      // One extra step after a capture lets the sampler drop its fresh flag
      .ce(ce && !generator_off && (!ready_r || fresh)),
      .run(1'b1),
      .noise_in(noise_in),
      .fresh(fresh),
      .sample(sample)
   );

   function automatic logic [31:0] read_word(input logic [31:0] addr, input logic [31:0] cfg,
                                            input logic rdy, input logic [15:0] val);
      read_word = 32'h0000_0000;
      unique case (addr[3:0])
         noise_pkg::CONFIG_OFF[3:0]: read_word = cfg;
         noise_pkg::STATUS_OFF[3:0]: read_word = {31'h0000_0000, rdy};
         noise_pkg::OUTPUT_OFF[3:0]: read_word = {16'h0000, val};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   // Bus phase tracking; a value read waits here while no value is ready
   always_comb
   begin
      phase_nxt = IDLE;
      req_nxt = req_r;
      hrdata_nxt = hrdata_r;
      value_read_done = 1'b0;
      unique case (phase_r)
         IDLE, WRITE:
         begin
            if (take)
            begin
               req_nxt.addr = haddr;
               req_nxt.write = hwrite;
               req_nxt.is_value = (haddr[3:0] == noise_pkg::OUTPUT_OFF[3:0]);
               if (hwrite)
                  phase_nxt = WRITE;
               else if (req_nxt.is_value && !ready_r)
                  phase_nxt = WAIT_VALUE;
               else
               begin
                  hrdata_nxt = read_word(haddr, config_reg_r, ready_r, sample_output_reg_r);
                  value_read_done = req_nxt.is_value && ready_r;
               end
            end
         end
         WAIT_VALUE:
         begin
            // Hold the host until a fresh value lands; disable means a stall that lasts until reset
            if (ready_r)
            begin
               hrdata_nxt = {16'h0000, sample_output_reg_r};
               value_read_done = 1'b1;
            end
            else
               phase_nxt = WAIT_VALUE;
         end
         default: phase_nxt = IDLE;
      endcase
   end

   // Register file: config write, ready flag and value capture
   always_comb
   begin
      config_reg_nxt = config_reg_r;
      ready_nxt = ready_r;
      sample_output_reg_nxt = sample_output_reg_r;
      if (phase_r == WRITE && req_r.addr[3:0] == noise_pkg::CONFIG_OFF[3:0])
         config_reg_nxt = hwdata; // reserved bits kept as written
      if (value_read_done)
         ready_nxt = 1'b0;
      if (fresh_ev)
      begin
         sample_output_reg_nxt = sample;
         ready_nxt = 1'b1;
      end
      if (config_reg_nxt[noise_pkg::GENERATOR_OFF_BIT])
         ready_nxt = 1'b0;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         phase_r <= IDLE;
         req_r <= '0;
         hrdata_r <= 32'h0000_0000;
         config_reg_r <= noise_pkg::CONFIG_RESET;
         ready_r <= 1'b0;
         sample_output_reg_r <= noise_pkg::OUTPUT_RESET;
      end
      else if (ce)
      begin
         phase_r <= phase_nxt;
         req_r <= req_nxt;
         hrdata_r <= hrdata_nxt;
         config_reg_r <= config_reg_nxt;
         ready_r <= ready_nxt;
         sample_output_reg_r <= sample_output_reg_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = (phase_r != WAIT_VALUE);
   assign hresp = 1'b0;

   ready_needs_on_a: assert property (@(posedge mclk) disable iff (!resetn)
      generator_off |-> !ready_r) else $error("ready high while disabled");
   stall_ready_a: assert property (@(posedge mclk) disable iff (!resetn)
      (phase_r == WAIT_VALUE) |-> !hreadyout) else $error("value read not stalled");
   read_clears_ready_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && value_read_done && !fresh_ev) |=> !ready_r) else $error("ready kept after read");
   upper_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
      (phase_r == WAIT_VALUE && ready_r && ce) |=> hrdata_r[31:16] == 16'h0000)
      else $error("value upper bits nonzero");
   fresh_sets_ready_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && fresh_ev && !config_reg_nxt[noise_pkg::GENERATOR_OFF_BIT]) |=> ready_r)
      else $error("fresh value not flagged");
   fresh_spacing_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && fresh_ev) |=> !fresh_ev) else $error("fresh values back to back");
   value_capture_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && fresh_ev) |=> sample_output_reg_r == $past(sample))
      else $error("value not captured");
   // A rise of ready always follows a fresh word from the sampler
   ready_source_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(ready_r) |-> $past(fresh_ev)) else $error("ready rose without value");
   // Only a value read may hold the host
   stall_value_only_a: assert property (@(posedge mclk) disable iff (!resetn)
      !hreadyout |-> (req_r.is_value && !req_r.write)) else $error("stall on other access");
   // A stopped generator never hands over a word
   off_no_fresh_a: assert property (@(posedge mclk) disable iff (!resetn)
      generator_off |-> !fresh_ev) else $error("fresh word while disabled");
   // Status read shows only the ready flag, upper bits zero
   status_upper_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && phase_r != WAIT_VALUE && hsel && hready && htrans[1] && !hwrite &&
       haddr[3:0] == noise_pkg::STATUS_OFF[3:0]) |=> hrdata_r[31:1] == 31'h0000_0000)
      else $error("status upper bits nonzero");
   config_write_a: assert property (@(posedge mclk) disable iff (!resetn)
      (ce && phase_r == WRITE && req_r.addr[3:0] == 4'h0) |=> config_reg_r == $past(hwdata))
      else $error("config write lost");
endmodule
`default_nettype wire

// [src/noise_pkg.sv]
// Package for the random number generator register block.
// Assumes a single 200 MHz clock domain and an AHB-lite slave port.
`default_nettype none
package noise_pkg;
   localparam logic [31:0] CONFIG_OFF = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFF = 32'h0000_0004;
   localparam logic [31:0] OUTPUT_OFF = 32'h0000_0008;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [15:0] OUTPUT_RESET = 16'h0000;
   localparam int GENERATOR_OFF_BIT = 2;
   localparam int READY_BIT = 0;
   localparam int SAMPLE_WIDTH = 16;
   // Spacing between fresh values, in picoseconds, and in cycles
   localparam int SPACING_PS = 1250000;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SPACING_CYCLES = (SPACING_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [15:0] LFSR_SEED = 16'h0000_ACE1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h0_2;
   localparam logic [2:0] HSIZE_WORD = 3'h0_2;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic is_value;
   } bus_req_type;
endpackage
`default_nettype wire

// [src/noise_sampler.sv]
// Sampler: builds a 16-bit word from the noise input, one per spacing interval.
// Assumes noise_in is synchronous; a free LFSR whitens it.
`default_nettype none
module noise_sampler #(
   parameter int SPACING = noise_pkg::SPACING_CYCLES,
   parameter int WIDTH = noise_pkg::SAMPLE_WIDTH
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic run,
   input wire logic noise_in,
   output logic fresh,
   output logic [WIDTH-1:0] sample
);
   logic [WIDTH-1:0] lfsr_r, lfsr_nxt;
   logic [15:0] count_r, count_nxt;
   logic fresh_r, fresh_nxt;
   logic [WIDTH-1:0] sample_r, sample_nxt;

   // Mix noise into LFSR; emit a word every SPACING cycles while running
   always_comb
   begin
      lfsr_nxt = lfsr_r;
      count_nxt = count_r;
      fresh_nxt = 1'b0;
      sample_nxt = sample_r;
      if (run)
      begin
         lfsr_nxt = {lfsr_r[WIDTH-2:0],
                     lfsr_r[WIDTH-1] ^ lfsr_r[WIDTH-3] ^ lfsr_r[WIDTH-4] ^
                     lfsr_r[WIDTH-6] ^ noise_in};
         if (count_r == 16'(SPACING - 1))
         begin
            count_nxt = 16'h0000;
            fresh_nxt = 1'b1;
            sample_nxt = lfsr_r;
         end
         else
         begin
            count_nxt = count_r + 16'h0001;
         end
      end
      else
      begin
         count_nxt = 16'h0000; // Restart the interval on re-enable
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         lfsr_r <= noise_pkg::LFSR_SEED;
         count_r <= 16'h0000;
         fresh_r <= 1'b0;
         sample_r <= '0;
      end
      else if (ce)
      begin
         lfsr_r <= lfsr_nxt;
         count_r <= count_nxt;
         fresh_r <= fresh_nxt;
         sample_r <= sample_nxt;
      end
   end

   assign fresh = fresh_r;
   assign sample = sample_r;
endmodule
`default_nettype wire

// [sim/noise_host.sv]
// Host model: a word-only bus master for the random number block.
// Assumes hready of the slave loops back to hreadyout; tasks start 1 ns after an edge.
`default_nettype none
module noise_host (
   input wire logic mclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic [2:0] hsize,
   output logic hwrite,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      hsel = 0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hsize = noise_pkg::HSIZE_WORD;
      hwrite = 0;
      hwdata = 32'h0000_0000;
   end
   // Address phase, then data phase; released lines show inverted values
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel = 1;
      htrans = noise_pkg::HTRANS_NONSEQ;
      hsize = noise_pkg::HSIZE_WORD;
      haddr = a;
      hwrite = w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      #1;
      hsel = 0;
      htrans = 2'h0;
      haddr = ~a;
      hwdata = w ? d : ~hwdata;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
      #1 hwdata = ~hwdata;
   endtask
endmodule
`default_nettype wire

// [sim/tb_noise_random_source_regs.sv]
// Testbench of the random number register block against an integer model.
// Assumes one slave on the bus and a short generation spacing.
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_noise_random_source_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SP = 4;
   logic mclk, resetn, noise_in, hsel, hwrite, hreadyout, hresp, generator_off;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [31:0] rs = 32'h0001_2739;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int err_total, check_count, cyc, stalls, cfg_m;
   int done_q[$];
   noise_random_source_regs #(.SPACING(SP)) DUT (.mclk(mclk), .resetn(resetn), .ce(1'b1),
      .noise_in(noise_in), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hsize(hsize),
      .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .generator_off(generator_off));
   noise_host host (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic rd(input logic [31:0] a);
      host.xfer(1'b0, a, 32'h0000_0000, q);
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end
   // Cycle count at the edge; stall count and fresh noise settled 1 ns after it
   always @(posedge mclk)
   begin
      cyc++;
      #1;
      stalls += (hreadyout === 1'b0);
      rs = xs(rs);
      noise_in = rs[0];
   end
   // A hung stall must not run forever
   initial
   begin
      #(5 * 4000);
      err_total++;
      complete_run;
   end
   initial
   begin
      resetn = 0;
      noise_in = 0;
      cfg_m = 0;
      repeat (12) @(posedge mclk);
      #1 resetn = 1;
      rd(noise_pkg::STATUS_OFF);
      `CHK("status_reset", 32'h0000_0000, q)
      rd(noise_pkg::CONFIG_OFF);
      `CHK("config_reset", 32'h0000_0000, q)
      rd(32'h0000_000C);
      `CHK("unmapped", 32'h0000_0000, q)
      wait_c(3 * SP);
      rd(noise_pkg::STATUS_OFF);
      `CHK("status_ready", 32'h0000_0001, q)
      // Back-to-back value reads: later ones must stall for a fresh word
      for (int i = 0; i < 4; i++)
      begin
         rd(noise_pkg::OUTPUT_OFF);
         `CHK("value_upper", 16'h0000, q[31:16])
         done_q.push_back(cyc);
      end
      for (int i = 1; i < 4; i++)
         `CHK("spacing", 1'b1, (done_q[i] - done_q[i-1]) >= SP)
      `CHK("stalled", 1'b1, stalls > 0)
      `CHK("resp", 1'b0, hresp)
      rd(noise_pkg::STATUS_OFF);
      `CHK("status_cleared", 32'h0000_0000, q)
      // Off, then on, then a random on/off sequence; reserved fields kept at zero
      for (int i = 0; i < 6; i++)
      begin
         rs = xs(rs);
         cfg_m = (i < 2) ? 4 - 4 * i : int'(rs & 32'h0000_0004);
         host.xfer(1'b1, noise_pkg::CONFIG_OFF, 32'(cfg_m), q);
         `CHK("generator_off", cfg_m[2], generator_off)
         wait_c(3 * SP);
         rd(noise_pkg::STATUS_OFF);
         `CHK("status_onoff", {31'h0, ~cfg_m[2]}, q)
         rd(noise_pkg::CONFIG_OFF);
         `CHK("config_rw", 32'(cfg_m), q)
      end
      complete_run;
   end
endmodule
`default_nettype wire
